// >>> include/usart_host_pkg.sv
/*
 Constants for the serial interface host front end: bus widths, mode and
 command field positions, status bit layout and buffer depth.
 Assumes a single 125 MHz core clock.
*/
package usart_host_pkg;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int CLK_PERIOD_NS = 8;
  // Mode word fields
  localparam int MODE_MULT_LSB = 0;   // 00 sync, 01 x1, 10 x16, 11 x64
  localparam int MODE_LEN_LSB = 2;    // 00..11 -> 5..8 bits
  localparam int MODE_PAR_EN = 4;
  localparam int MODE_PAR_EVEN = 5;
  localparam int MODE_STOP_LSB = 6;   // 01 one, 10 one and a half, 11 two
  // Command word fields
  localparam int CMD_TX_EN = 0;
  localparam int CMD_RX_EN = 2;
  localparam int CMD_BREAK = 3;
  localparam int CMD_ERR_CLR = 4;
  localparam int CMD_RESET = 6;
  // Status bit positions
  localparam int ST_TX_RDY = 0;
  localparam int ST_RX_RDY = 1;
  localparam int ST_TX_EMPTY = 2;
  localparam int ST_PAR_ERR = 3;
  localparam int ST_OVR_ERR = 4;
  localparam int ST_FRM_ERR = 5;
  localparam int ST_SYNC = 6;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] CMD_RST = 8'h00;
  // Least clock ratios, scaled by two so 4.5 stays whole
  localparam int RATIO_SYNC_X2 = 60;
  localparam int RATIO_ASYNC_X2 = 9;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT_CMD, ST_RUN} cfg_state_t;
endpackage : usart_host_pkg

// >>> hdl/usart_fifo.sv
/*
 Parameterised first-in first-out buffer with valid/ready on both sides.
 Assumes both sides run on the same clock.
*/
`timescale 1ns/1ps
module usart_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  // Honest full and empty from the occupancy count
  assign in_ready = (cnt_r != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage, no reset needed on data
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + AW'(1);
      if (pop) rp_r <= rp_r + AW'(1);
      if (push && !pop) cnt_r <= cnt_r + (AW+1)'(1);
      else if (pop && !push) cnt_r <= cnt_r - (AW+1)'(1);
    end
  end
endmodule : usart_fifo

// >>> hdl/usart_host_bus_interface.sv
/*
 Host-side front end of the serial interface: data bus buffer, strobe
 decode, mode and command registers, status and ready signalling.
 Assumes asynchronous host strobes; the serial engines sit outside and
 talk over the tx/rx stream ports below.
*/
// Contract
// R1: Reset forces idle; stays idle until mode then command words are written.
// R2: System clock must exceed 30x (sync) or 4.5x (async) bit clock.
// R3: Low write strobe with chip select is a host write cycle.
// R4: Low read strobe with chip select is a read; device drives the value.
// R5: One 8-bit three-state bus carries data, control words and status.
// R6: Separate mode and command registers define the configuration.
// R7: Signal transmit ready and receive ready separately.
// R8: Status readable any time: errors, sync found, transmitter drained.
// R9: Async: 5-8 bit characters, x1/x16/x64 clock, 1/1.5/2 stops, break.
// R10: Parity, overrun and framing errors are reported in status.
// R11: Control/data high selects control/status, low selects data.
// R12: Strobes ignored unless chip select is low.
// R13: Bus driven only during a selected read, otherwise released.
`timescale 1ns/1ps
module usart_host_bus_interface
  import usart_host_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic cd,
  input wire logic [7:0] db_in,
  output logic [7:0] db_out,
  output logic db_oe_n,
  output logic tx_ready,
  output logic rx_ready,
  output logic [7:0] tx_char,
  output logic tx_char_valid,
  input wire logic tx_char_ready,
  input wire logic [7:0] rx_char,
  input wire logic rx_char_valid,
  output logic rx_char_ready,
  input wire logic rx_par_err,
  input wire logic rx_frm_err,
  input wire logic sync_found_flag,
  input wire logic transmitter_drained_flag,
  output logic configured,
  output logic tx_enable,
  output logic rx_enable,
  output logic send_break,
  output logic [1:0] clock_mult,
  output logic [3:0] char_bits,
  output logic parity_en,
  output logic parity_even,
  output logic [1:0] stop_bits
);
  // Three-stage synchronisers for the host control pins, two stages for the data bus
  logic [2:0] cs_s_r, rd_s_r, wr_s_r, cd_s_r;
  logic [7:0] db_s1_r, db_s2_r;
  logic rd_act, wr_act, rd_prev_r, wr_prev_r, wr_fall, rd_rise;
  logic rd_lvl_r, wr_lvl_r;
  logic [7:0] mode_r, cmd_r, db_out_r, fifo_din;
  logic rx_full_r, ovr_r, perr_r, ferr_r, wr_cd_r, fifo_in_ready, sync_r;
  logic [7:0] rx_hold_r;
  cfg_state_t state_r;

  // A pin counts once stages two and three agree
  function automatic logic agreed(input logic [2:0] s, input logic prev);
    agreed = (s[1] == s[2]) ? s[2] : prev;
  endfunction : agreed

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cs_s_r <= 3'h7;
      rd_s_r <= 3'h7;
      wr_s_r <= 3'h7;
      cd_s_r <= 3'h0;
      db_s1_r <= 8'h00;
      db_s2_r <= 8'h00;
      rd_lvl_r <= 1'b1;
      wr_lvl_r <= 1'b1;
    end else begin
      // Filtered strobe levels hold their last agreed pin value
      rd_lvl_r <= agreed(rd_s_r, rd_lvl_r);
      wr_lvl_r <= agreed(wr_s_r, wr_lvl_r);
      cs_s_r <= {cs_s_r[1:0], cs_n};
      rd_s_r <= {rd_s_r[1:0], rd_n};
      wr_s_r <= {wr_s_r[1:0], wr_n};
      cd_s_r <= {cd_s_r[1:0], cd};
      db_s1_r <= db_in;
      db_s2_r <= db_s1_r;
    end
  end

  // Cycle qualification by chip select
  assign rd_act = !rd_lvl_r && !cs_s_r[2] && cs_s_r[1] == cs_s_r[2]; // [R4] [R12]
  assign wr_act = !wr_lvl_r && !cs_s_r[2] && cs_s_r[1] == cs_s_r[2]; // [R3] [R12]

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_prev_r <= 1'b0;
      wr_prev_r <= 1'b0;
      wr_cd_r <= 1'b0;
    end else begin
      rd_prev_r <= rd_act;
      wr_prev_r <= wr_act;
      if (wr_act) wr_cd_r <= cd_s_r[2];
    end
  end
  // Write acts at strobe release so bus data has settled
  assign wr_fall = wr_prev_r && !wr_act; // [R3]
  assign rd_rise = rd_prev_r && !rd_act;

  // Mode first, then command; reset returns to idle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE; // [R1]
      mode_r <= MODE_RST;
      cmd_r <= CMD_RST;
    end else if (wr_fall && wr_cd_r) begin // [R11]
      unique case (state_r)
        ST_IDLE: begin
          mode_r <= db_s2_r; // [R6]
          state_r <= ST_WAIT_CMD;
        end
        ST_WAIT_CMD, ST_RUN: begin
          if (db_s2_r[CMD_RESET]) begin
            state_r <= ST_IDLE; // [R1]
            cmd_r <= CMD_RST;
          end else begin
            cmd_r <= db_s2_r; // [R6]
            state_r <= ST_RUN;
          end
        end
      endcase
    end
  end

  assign configured = (state_r == ST_RUN); // [R1]
  assign tx_enable = configured && cmd_r[CMD_TX_EN];
  assign rx_enable = configured && cmd_r[CMD_RX_EN];
  assign send_break = configured && cmd_r[CMD_BREAK]; // [R9]
  assign clock_mult = mode_r[MODE_MULT_LSB +: 2]; // [R9]
  assign char_bits = 4'h5 + {2'b00, mode_r[MODE_LEN_LSB +: 2]}; // [R9]
  assign parity_en = mode_r[MODE_PAR_EN];
  assign parity_even = mode_r[MODE_PAR_EVEN];
  assign stop_bits = mode_r[MODE_STOP_LSB +: 2]; // [R9]

  // Transmit characters are buffered; full FIFO drops tx_ready
  assign fifo_din = db_s2_r;
  usart_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) tx_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(wr_fall && !wr_cd_r && configured),
    .in_ready(fifo_in_ready),
    .in_data(fifo_din),
    .out_valid(tx_char_valid),
    .out_ready(tx_char_ready && tx_enable),
    .out_data(tx_char)
  );
  assign tx_ready = configured && tx_enable && fifo_in_ready; // [R7]

  // Receive holding register and error flags; set wins over clear
  assign rx_char_ready = !rx_full_r || (rd_rise && !cd_s_r[2]);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_full_r <= 1'b0;
      rx_hold_r <= 8'h00;
      ovr_r <= 1'b0;
      perr_r <= 1'b0;
      ferr_r <= 1'b0;
    end else begin
      if (rx_char_valid && rx_enable) begin
        rx_hold_r <= rx_char;
        rx_full_r <= 1'b1; // [R7]
      end else if (rd_rise && !cd_s_r[2]) begin
        rx_full_r <= 1'b0;
      end
      if (rx_char_valid && rx_enable && rx_full_r && !(rd_rise && !cd_s_r[2])) ovr_r <= 1'b1; // [R10]
      else if (wr_fall && wr_cd_r && db_s2_r[CMD_ERR_CLR] && state_r != ST_IDLE) ovr_r <= 1'b0;
      if (rx_char_valid && rx_enable && rx_par_err) perr_r <= 1'b1; // [R10]
      else if (wr_fall && wr_cd_r && db_s2_r[CMD_ERR_CLR] && state_r != ST_IDLE) perr_r <= 1'b0;
      if (rx_char_valid && rx_enable && rx_frm_err) ferr_r <= 1'b1; // [R10]
      else if (wr_fall && wr_cd_r && db_s2_r[CMD_ERR_CLR] && state_r != ST_IDLE) ferr_r <= 1'b0;
    end
  end
  assign rx_ready = rx_full_r; // [R7]

  // Sync flag latched, cleared by a status read unless set again
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) sync_r <= 1'b0;
    else if (sync_found_flag) sync_r <= 1'b1;
    else if (rd_rise && cd_s_r[2]) sync_r <= 1'b0;
  end

  // Read data registered; status or received character by select
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) db_out_r <= 8'h00;
    else if (rd_act && cd_s_r[2]) // [R8] [R11]
      db_out_r <= {1'b0, sync_r, ferr_r, ovr_r, perr_r, transmitter_drained_flag,
                   rx_full_r, tx_ready};
    else if (rd_act) db_out_r <= rx_hold_r; // [R4]
  end
  assign db_out = db_out_r; // [R5]
  assign db_oe_n = !(rd_act && rd_prev_r); // [R13]

  // Driving only after the value is loaded
  property p_bus_release;
    @(posedge core_clk) disable iff (rst) !rd_act |-> db_oe_n;
  endproperty
  a_bus_release: assert property (p_bus_release) else $error("bus driven outside read"); // [R13]
  property p_idle_after_reset;
    @(posedge core_clk) disable iff (rst) (state_r == ST_IDLE) |-> !tx_ready && !configured;
  endproperty
  a_idle_after_reset: assert property (p_idle_after_reset) else $error("active while idle"); // [R1]
  property p_rx_ready;
    @(posedge core_clk) disable iff (rst) (rx_char_valid && rx_enable) |=> rx_ready;
  endproperty
  a_rx_ready: assert property (p_rx_ready) else $error("rx ready missing"); // [R7]
  property p_overrun;
    @(posedge core_clk) disable iff (rst)
      (rx_char_valid && rx_enable && rx_full_r && !rd_rise) |=> ovr_r;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged"); // [R10]
  property p_no_cs;
    @(posedge core_clk) disable iff (rst) cs_s_r[2] && cs_s_r[1] |-> !rd_act && !wr_act;
  endproperty
  a_no_cs: assert property (p_no_cs) else $error("strobe taken without select"); // [R12]
  sequence s_cmd_write;
    wr_fall && wr_cd_r && state_r == ST_WAIT_CMD && !db_s2_r[CMD_RESET];
  endsequence
  property p_cmd_run;
    @(posedge core_clk) disable iff (rst) s_cmd_write |=> configured && cmd_r == $past(db_s2_r);
  endproperty
  a_cmd_run: assert property (p_cmd_run) else $error("command not stored"); // [R6]
  property p_status;
    @(posedge core_clk) disable iff (rst) rd_act && cd_s_r[2] |=> db_out[5] == $past(ferr_r);
  endproperty
  a_status: assert property (p_status) else $error("status wrong"); // [R8]
  property p_data_read;
    @(posedge core_clk) disable iff (rst) rd_act && !cd_s_r[2] |=> db_out == $past(rx_hold_r);
  endproperty
  a_data_read: assert property (p_data_read) else $error("data read wrong"); // [R4]
endmodule : usart_host_bus_interface

// >>> dv/host_cpu_model.sv
/*
 Host processor bus model: chip select, strobes, control/data select, bus.
 Assumes the device samples strobes on core_clk; one access at a time.
*/
`timescale 1ns/1ps
module host_cpu_model (
  input wire logic core_clk,
  input wire logic [7:0] db_out,
  input wire logic db_oe_n,
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic cd,
  output logic [7:0] db_in
);
  logic drv;
  logic [7:0] hd;
  logic [7:0] last;
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    cd = 1'b0;
    drv = 1'b0;
    hd = 8'h00;
    last = 8'h00;
  end
  // Wire level; a floating bus toggles so stale data never looks valid
  always_comb db_in = !db_oe_n ? db_out : (drv ? hd : ~last);
  always @(posedge core_clk) last <= db_in;
  // One bus cycle; strobe held 10 clocks, address and data well past it
  task automatic access(input logic sel, input logic c, input logic wr, input logic [7:0] d,
                        output logic [7:0] q, output logic oe_n);
    @(posedge core_clk);
    cs_n <= !sel;
    cd <= c;
    hd <= d;
    drv <= wr;
    repeat (2) @(posedge core_clk);
    if (wr) wr_n <= 1'b0;
    else rd_n <= 1'b0;
    repeat (10) @(posedge core_clk);
    q = db_in;
    oe_n = db_oe_n;
    wr_n <= 1'b1;
    rd_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    cs_n <= 1'b1;
    drv <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask : access
endmodule : host_cpu_model

// >>> dv/testbench.sv
/*
 Self-checking bench for the host front end: configuration, transmit
 buffer fill and drain, receive status and data, deselected strobes.
 Assumes the host model above and the package constants.
*/
`timescale 1ns/1ps
module testbench;
  import usart_host_pkg::*;
  logic core_clk, rst, tx_char_ready, rx_char_valid, rx_par_err, rx_frm_err;
  logic sync_found_flag, transmitter_drained_flag, cs_n, rd_n, wr_n, cd, db_oe_n;
  logic tx_ready, rx_ready, tx_char_valid, configured, tx_enable, rx_enable, send_break;
  logic parity_en, parity_even, oe, rx_char_ready;
  logic [7:0] db_in, db_out, tx_char, rx_char, q, m, rxv;
  logic [1:0] clock_mult, stop_bits;
  logic [3:0] char_bits;
  logic [7:0] exp_q[$];
  logic [7:0] got_q[$];
  int num_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  // Clock well above any bit clock ratio
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  host_cpu_model host (.core_clk(core_clk), .db_out(db_out), .db_oe_n(db_oe_n), .cs_n(cs_n),
    .rd_n(rd_n), .wr_n(wr_n), .cd(cd), .db_in(db_in));
  usart_host_bus_interface uut (.core_clk(core_clk), .rst(rst), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .cd(cd), .db_in(db_in), .db_out(db_out), .db_oe_n(db_oe_n),
    .tx_ready(tx_ready), .rx_ready(rx_ready), .tx_char(tx_char), .tx_char_valid(tx_char_valid),
    .tx_char_ready(tx_char_ready), .rx_char(rx_char), .rx_char_valid(rx_char_valid),
    .rx_char_ready(rx_char_ready), .rx_par_err(rx_par_err), .rx_frm_err(rx_frm_err),
    .sync_found_flag(sync_found_flag), .transmitter_drained_flag(transmitter_drained_flag),
    .configured(configured), .tx_enable(tx_enable), .rx_enable(rx_enable),
    .send_break(send_break), .clock_mult(clock_mult), .char_bits(char_bits),
    .parity_en(parity_en), .parity_even(parity_even), .stop_bits(stop_bits));
  // Collect what the serial side takes off the buffer
  always @(posedge core_clk) if (tx_char_valid === 1'b1 && tx_char_ready === 1'b1) got_q.push_back(tx_char);
  // Hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      end_sim();
    end
  end
  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_val
  task automatic chk_bit(input logic got, input logic exp);
    chk_val({7'h00, got}, {7'h00, exp});
  endtask : chk_bit
  task automatic end_sim();
    $display("errors %0d comparisons %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  // Status with the transmit-ready bit masked off
  function automatic logic [7:0] exp_status(logic pe, logic ov, logic fe, logic drn);
    return {1'b0, 1'b1, fe, ov, pe, drn, 2'b10};
  endfunction : exp_status
  task automatic wr(input logic c, input logic [7:0] d);
    host.access(1'b1, c, 1'b1, d, q, oe);
  endtask : wr
  task automatic rx_send(input logic pe, input logic fe);
    rxv = $urandom;
    @(posedge core_clk);
    rx_char <= rxv;
    rx_par_err <= pe;
    rx_frm_err <= fe;
    rx_char_valid <= 1'b1;
    sync_found_flag <= 1'b1;
    @(posedge core_clk);
    rx_char_valid <= 1'b0;
    sync_found_flag <= 1'b0;
  endtask : rx_send
  initial begin
    rst = 1'b1;
    {tx_char_ready, rx_char_valid, rx_par_err, rx_frm_err, sync_found_flag} = 5'h00;
    transmitter_drained_flag = 1'b1;
    rx_char = 8'h00;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    void'($urandom(32'he56dec96));
    chk_bit(db_oe_n, 1'b1);
    chk_bit(configured, 1'b0);
    wr(1'b0, 8'h5a);
    chk_bit(tx_char_valid, 1'b0);
    m = $urandom;
    m[7:6] = 2'($urandom_range(3, 1));
    wr(1'b1, m);
    wr(1'b1, 8'h05);
    chk_val({clock_mult, stop_bits, parity_en, parity_even, 2'b00}, {m[1:0], m[7:6], m[4], m[5], 2'b00});
    chk_val({4'h0, char_bits}, {4'h0, 2'b00, m[3:2]} + 8'h05);
    chk_val({configured, tx_enable, rx_enable}, 3'b111);
    host.access(1'b0, 1'b1, 1'b1, 8'h40, q, oe);
    chk_bit(configured, 1'b1);
    wr(1'b1, 8'h0d);
    chk_bit(send_break, 1'b1);
    wr(1'b1, 8'h05);
    // Fill past depth while the serial side stalls; the extra byte is refused
    for (int i = 0; i <= FIFO_DEPTH; i++) begin
      m = $urandom;
      if (i < FIFO_DEPTH) exp_q.push_back(m);
      wr(1'b0, m);
    end
    chk_bit(tx_ready, 1'b0);
    tx_char_ready <= 1'b1;
    repeat (40) @(posedge core_clk);
    chk_val(8'(got_q.size()), 8'(FIFO_DEPTH));
    foreach (exp_q[i]) chk_val(got_q[i], exp_q[i]);
    chk_bit(tx_ready, 1'b1);
    // Parity, framing, then overrun by two unread characters
    for (int k = 0; k < 3; k++) begin
      transmitter_drained_flag <= k[0];
      rx_send(k == 0, k == 1);
      if (k == 2) rx_send(1'b0, 1'b0);
      repeat (4) @(posedge core_clk);
      chk_bit(rx_ready, 1'b1);
      chk_bit(rx_char_ready, 1'b0);
      host.access(1'b1, 1'b1, 1'b0, 8'h00, q, oe);
      chk_bit(oe, 1'b0);
      chk_val(q & 8'hfe, exp_status(k == 0, k == 2, k == 1, k[0]) | 8'h40);
      host.access(1'b1, 1'b0, 1'b0, 8'h00, q, oe);
      chk_val(q, rxv);
      chk_bit(rx_ready, 1'b0);
      chk_bit(rx_char_ready, 1'b1);
      wr(1'b1, 8'h15);
    end
    chk_bit(db_oe_n, 1'b1);
    wr(1'b1, 8'h40);
    chk_bit(configured, 1'b0);
    end_sim();
  end
endmodule : testbench
